// file: src/crcsh_engine.sv
`timescale 1ns/10ps
// ==========================================================
// programmable checksum engine with APB register access
// ==========================================================
module crcsh_engine
   import crcsh_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             busyStatus
);

   // ==========================================================
   // reset release
   // ==========================================================
   logic        rstMeta_n;
   logic        rst_n;

   // async assert, release through two flops to avoid recovery hazards
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_n <= 1'b0;
         rst_n     <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rst_n     <= rstMeta_n;
      end
   end

   // ==========================================================
   // state
   // ==========================================================
   logic [31:0] checksumInputData;
   logic [31:0] checksumResult;
   logic [31:0] feedbackTaps;
   logic [31:0] serialShiftReg;
   logic [4:0]  polyOrderMinusOne;
   logic [4:0]  wordBitsMinusOne;
   logic        enable;
   logic        start;
   logic        accMode;
   crcsh_sel_t  overlaySel;
   logic        shiftDirection;
   logic        dataFull;
   logic [5:0]  bitsLeft;

   // ==========================================================
   // bus decode
   // ==========================================================
   logic [15:0] regIndex;
   logic        aligned;
   logic        hitInput;
   logic        hitResult;
   logic        hitMain;
   logic        hitPoly;
   logic        hitData;
   logic        mapped;
   logic        wrDone;
   logic        wrOk;
   logic [7:0]  mainRead;
   logic [31:0] overlayRead;
   logic [31:0] next_rdata;

   assign regIndex  = {2'b00, paddr[15:2]};
   assign aligned   = (paddr[1:0] == 2'b00);
   assign hitInput  = aligned && (regIndex == CRCSH_IDX_INPUT);
   assign hitResult = aligned && (regIndex == CRCSH_IDX_RESULT);
   assign hitMain   = aligned && (regIndex == CRCSH_IDX_MAIN);
   assign hitPoly   = aligned && (regIndex == CRCSH_IDX_POLYLEN);
   assign hitData   = aligned && (regIndex == CRCSH_IDX_DATALEN);
   assign mapped    = hitInput | hitResult | hitMain | hitPoly | hitData;
   // a write lands only at the completing edge of the access phase
   assign wrDone    = psel && penable && pready && pwrite;
   assign wrOk      = wrDone && mapped;

   // main control as software sees it
   always_comb begin
      mainRead                   = 8'h00;
      mainRead[CRCSH_BIT_EN]     = enable;
      mainRead[CRCSH_BIT_GO]     = start;
      mainRead[CRCSH_BIT_BUSY]   = busyStatus;
      mainRead[CRCSH_BIT_ACCM]   = accMode;
      mainRead[CRCSH_BIT_SEL_HI:CRCSH_BIT_SEL_LO] = overlaySel;
      mainRead[CRCSH_BIT_DIR]    = shiftDirection;
      mainRead[CRCSH_BIT_FULL]   = dataFull;
   end

   // overlay picks which word sits at the result location
   always_comb begin
      unique case (overlaySel)
         CRCSH_SEL_RESULT0: overlayRead = checksumResult;
         CRCSH_SEL_RESULT3: overlayRead = checksumResult;
         CRCSH_SEL_TAPS:    overlayRead = feedbackTaps;
         CRCSH_SEL_SHIFT:   overlayRead = serialShiftReg;
      endcase
   end

   // read mux; narrow registers sit in the low bits
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hitInput) begin
         next_rdata = checksumInputData;
      end else if (hitResult) begin
         next_rdata = overlayRead;
      end else if (hitMain) begin
         next_rdata = {24'h000000, mainRead};
      end else if (hitPoly) begin
         next_rdata = {27'h0000000, polyOrderMinusOne};
      end else if (hitData) begin
         next_rdata = {27'h0000000, wordBitsMinusOne};
      end
   end

   // one wait state so that read data comes from a flop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= CRCSH_RST_WORD;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // byte-lane merge for the 32-bit registers
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : laneMerge

   // ==========================================================
   // control registers
   // ==========================================================
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable         <= 1'b0;
         start          <= 1'b0;
         accMode        <= 1'b0;
         overlaySel     <= CRCSH_SEL_RESULT0;
         shiftDirection <= 1'b0;
      end else if (wrOk && hitMain && pstrb[0]) begin
         enable         <= pwdata[CRCSH_BIT_EN];
         start          <= pwdata[CRCSH_BIT_GO];
         accMode        <= pwdata[CRCSH_BIT_ACCM];
         overlaySel     <= crcsh_sel_t'(pwdata[CRCSH_BIT_SEL_HI:CRCSH_BIT_SEL_LO]);
         shiftDirection <= pwdata[CRCSH_BIT_DIR];
      end
   end

   // length fields, order and count both stored minus one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         polyOrderMinusOne <= CRCSH_RST_LEN;
         wordBitsMinusOne  <= CRCSH_RST_LEN;
      end else begin
         if (wrOk && hitPoly && pstrb[0]) begin
            polyOrderMinusOne <= pwdata[CRCSH_LEN_HI:0];
         end
         if (wrOk && hitData && pstrb[0]) begin
            wordBitsMinusOne <= pwdata[CRCSH_LEN_HI:0];
         end
      end
   end

   // ==========================================================
   // data path
   // ==========================================================
   logic        running;
   logic        loadWord;
   logic        stepBit;
   logic        dataBit;
   logic [31:0] next_acc;
   logic [31:0] wordMask;

   // clearing start or enable freezes the shifter where it stands
   assign running  = enable && start;
   assign loadWord = running && dataFull && (bitsLeft == CRCSH_CNT_ZERO);
   assign stepBit  = running && (bitsLeft != CRCSH_CNT_ZERO);
   assign wordMask = crcsh_len_mask(wordBitsMinusOne);

   // bit taken from the end that the direction selects
   always_comb begin
      if (shiftDirection) begin
         dataBit = serialShiftReg[0];
      end else begin
         dataBit = serialShiftReg[wordBitsMinusOne];
      end
   end

   crcsh_shift_step uStep (
      .accIn             (checksumResult),
      .taps              (feedbackTaps),
      .polyOrderMinusOne (polyOrderMinusOne),
      .dataBit           (dataBit),
      .accOut            (next_acc)
   );

   // input word; a fresh write sets full even if a load happens now
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         checksumInputData <= CRCSH_RST_WORD;
         dataFull          <= 1'b0;
      end else begin
         if (wrOk && hitInput) begin
            checksumInputData <= laneMerge(checksumInputData, pwdata, pstrb);
            dataFull          <= 1'b1;
         end else if (loadWord) begin
            dataFull <= 1'b0;
         end
      end
   end

   // shift register and bit counter; software write wins over hardware
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serialShiftReg <= CRCSH_RST_WORD;
         bitsLeft       <= CRCSH_CNT_ZERO;
      end else if (wrOk && hitResult && overlaySel == CRCSH_SEL_SHIFT) begin
         serialShiftReg <= laneMerge(serialShiftReg, pwdata, pstrb);
      end else if (loadWord) begin
         serialShiftReg <= checksumInputData & wordMask;
         bitsLeft       <= 6'(wordBitsMinusOne) + CRCSH_CNT_ONE;
      end else if (stepBit) begin
         if (shiftDirection) begin
            serialShiftReg <= serialShiftReg >> 1;
         end else begin
            serialShiftReg <= (serialShiftReg << 1) & wordMask;
         end
         bitsLeft <= bitsLeft - CRCSH_CNT_ONE;
      end
   end

   // accumulator; a software write to the overlay beats a shift step
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         checksumResult <= CRCSH_RST_WORD;
      end else if (wrOk && hitResult &&
                   (overlaySel == CRCSH_SEL_RESULT0 || overlaySel == CRCSH_SEL_RESULT3)) begin
         checksumResult <= laneMerge(checksumResult, pwdata, pstrb);
      end else if (stepBit) begin
         checksumResult <= next_acc;
      end
   end

   // polynomial taps, only reachable through the overlay
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         feedbackTaps <= CRCSH_RST_WORD;
      end else if (wrOk && hitResult && overlaySel == CRCSH_SEL_TAPS) begin
         feedbackTaps <= laneMerge(feedbackTaps, pwdata, pstrb);
      end
   end

   // busy covers a waiting word as well as bits still in flight
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busyStatus <= 1'b0;
      end else begin
         busyStatus <= running && (dataFull || (bitsLeft > CRCSH_CNT_ONE) ||
                       (bitsLeft == CRCSH_CNT_ONE && !stepBit));
      end
   end

endmodule : crcsh_engine

// file: pkg/crcsh_pkg.sv
package crcsh_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   // ==========================================================
   localparam logic [15:0] CRCSH_IDX_INPUT   = 16'h1C9A;
   localparam logic [15:0] CRCSH_IDX_RESULT  = 16'h1C9E;
   localparam logic [15:0] CRCSH_IDX_MAIN    = 16'h1CA2;
   localparam logic [15:0] CRCSH_IDX_POLYLEN = 16'h1CA3;
   localparam logic [15:0] CRCSH_IDX_DATALEN = 16'h1CA4;

   localparam int          CRCSH_ADDR_W      = 16;
   localparam int          CRCSH_DATA_W      = 32;
   localparam int          CRCSH_LEN_W       = 5;

   // ==========================================================
   // main control field positions
   // ==========================================================
   localparam int          CRCSH_BIT_EN      = 7;
   localparam int          CRCSH_BIT_GO      = 6;
   localparam int          CRCSH_BIT_BUSY    = 5;
   localparam int          CRCSH_BIT_ACCM    = 4;
   localparam int          CRCSH_BIT_SEL_HI  = 3;
   localparam int          CRCSH_BIT_SEL_LO  = 2;
   localparam int          CRCSH_BIT_DIR     = 1;
   localparam int          CRCSH_BIT_FULL    = 0;
   localparam int          CRCSH_LEN_HI      = 4;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [31:0] CRCSH_RST_WORD    = 32'h0000_0000;
   localparam logic [4:0]  CRCSH_RST_LEN     = 5'h00;
   localparam logic [5:0]  CRCSH_CNT_ZERO    = 6'h00;
   localparam logic [5:0]  CRCSH_CNT_ONE     = 6'h01;

   // overlay selection codes
   typedef enum logic [1:0] {
      CRCSH_SEL_RESULT0 = 2'h0,
      CRCSH_SEL_SHIFT   = 2'h1,
      CRCSH_SEL_TAPS    = 2'h2,
      CRCSH_SEL_RESULT3 = 2'h3
   } crcsh_sel_t;

   // ones in bits len..0, used for both polynomial and word lengths
   function automatic logic [31:0] crcsh_len_mask(input logic [4:0] len);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         m[i] = (5'(i) <= len);
      end
      return m;
   endfunction : crcsh_len_mask

endpackage : crcsh_pkg

// file: src/crcsh_shift_step.sv
`timescale 1ns/10ps
// ==========================================================
// one serial step of the checksum accumulator
// ==========================================================
module crcsh_shift_step
   import crcsh_pkg::*;
(
   input  wire logic [31:0] accIn,
   input  wire logic [31:0] taps,
   input  wire logic [4:0]  polyOrderMinusOne,
   input  wire logic        dataBit,
   output logic      [31:0] accOut
);
   logic [31:0] polyMask;
   logic        feedback;

   // feedback is the incoming bit against the accumulator's top bit
   always_comb begin
      polyMask = crcsh_len_mask(polyOrderMinusOne);
      feedback = dataBit ^ accIn[polyOrderMinusOne];
      accOut   = (accIn << 1) & polyMask;
      if (feedback) begin
         accOut = accOut ^ (taps & polyMask);
      end
   end
endmodule : crcsh_shift_step

// file: verif/crcsh_engine_properties.sv
`timescale 1ns/10ps
// ==========================================================
// port checks of the register interface
// ==========================================================
module crcsh_engine_properties (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        busyStatus
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // handshake shape: one wait state, one-cycle answer
   ready_one_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   one_wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("access phase not two cycles");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   // refused addresses answer with an error and zero data
   unaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("unaligned accepted");
   err_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   input_no_err_a: assert property (pready && paddr == 16'h7268 |-> !pslverr) else $error("input refused");
   // narrow fields read zero above their width
   poly_order_minus_one_upper_zero_a: assert property (pready && !pwrite && paddr == 16'h728C |-> prdata[31:5] == 27'h0)
      else $error("poly length upper bits set");
   word_bits_minus_one_upper_zero_a: assert property (pready && !pwrite && paddr == 16'h7290 |-> prdata[31:5] == 27'h0)
      else $error("data length upper bits set");

   cover property (pready && pslverr);
   cover property ($rose(busyStatus));
   cover property (pready && pwrite && paddr == 16'h7278);
endmodule : crcsh_engine_properties

bind crcsh_engine crcsh_engine_properties u_crcsh_engine_properties (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busyStatus(busyStatus));

// file: verif/crcsh_engine_bench.sv
`timescale 1ns/10ps
module crcsh_engine_bench
   import crcsh_pkg::*;
;
   // ==========================================================
   // signals and design
   // ==========================================================
   localparam logic [15:0] A_IN   = {CRCSH_IDX_INPUT[13:0], 2'b00};
   localparam logic [15:0] A_RES  = {CRCSH_IDX_RESULT[13:0], 2'b00};
   localparam logic [15:0] A_MAIN = {CRCSH_IDX_MAIN[13:0], 2'b00};
   localparam logic [15:0] A_POLY_ORDER_MINUS_ONE = {CRCSH_IDX_POLYLEN[13:0], 2'b00};
   localparam logic [15:0] A_WORD_BITS_MINUS_ONE = {CRCSH_IDX_DATALEN[13:0], 2'b00};
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [15:0] paddr   = 16'h0000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [3:0]  pstrb   = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busyStatus;
   int          bad_count = 0;
   int          n_checks  = 0;

   crcsh_engine u_crcsh_engine (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busyStatus(busyStatus));

   // free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : chk

   // one apb transfer; waits for pready, idles one cycle after
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed here; the watchdog ends a hang
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      chk("access cycles", 32'h2, 32'(n)); // one wait state
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, s, r, e);
   endtask : wr

   task automatic expect_rd(input logic [15:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, 4'h0, r, e);
      chk(what, exp, r);
   endtask : expect_rd

   // bit-serial reference; same accumulator form for both directions
   function automatic logic [31:0] crc_ref(input logic [31:0] din, input logic [31:0] tp, input int pl,
                                           input int dl, input bit dir);
      logic [31:0] acc;
      logic [31:0] sh;
      logic [31:0] m;
      logic        fb;
      acc = 32'h0;
      m = 32'h0;
      sh = din;
      for (int i = 0; i <= pl; i++) m[i] = 1'b1;
      for (int i = 0; i <= dl; i++) begin
         fb = (dir ? sh[0] : sh[dl]) ^ acc[pl];
         sh = dir ? sh >> 1 : sh << 1;
         acc = (acc << 1) & m;
         if (fb) acc = acc ^ (tp & m);
      end
      return acc;
   endfunction : crc_ref

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_reset;
      expect_rd(A_IN, 32'h0, "input reset");
      expect_rd(A_RES, 32'h0, "result reset");
      expect_rd(A_MAIN, 32'h0, "main reset");
      expect_rd(A_POLY_ORDER_MINUS_ONE, 32'h0, "poly_order_minus_one reset");
      expect_rd(A_WORD_BITS_MINUS_ONE, 32'h0, "word_bits_minus_one reset");
   endtask : t_reset

   // partial lane write, then narrow fields with upper garbage
   task automatic t_fields;
      wr(A_IN, 32'hA1B2_C3D4);
      wr(A_IN, 32'h5566_7788, 4'h5);
      expect_rd(A_IN, 32'hA166_C388, "input lanes");
      expect_rd(A_MAIN, 32'h01, "full set");
      wr(A_POLY_ORDER_MINUS_ONE, 32'hFFFF_FFFF);
      expect_rd(A_POLY_ORDER_MINUS_ONE, 32'h1F, "poly_order_minus_one field");
      wr(A_WORD_BITS_MINUS_ONE, 32'hFFFF_FFE3);
      expect_rd(A_WORD_BITS_MINUS_ONE, 32'h03, "word_bits_minus_one field");
   endtask : t_fields

   // unmapped and unaligned places are refused
   task automatic t_unmapped;
      logic [31:0] r;
      logic        e;
      apb(1'b0, 16'h7270, 32'h0, 4'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      apb(1'b0, A_IN + 16'h2, 32'h0, 4'h0, r, e);
      chk("unaligned err", 32'h1, {31'h0, e});
   endtask : t_unmapped

   // engine disabled, so overlay contents stay put
   task automatic t_overlay;
      logic [31:0] exp [4] = '{32'h1111_1111, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
      for (int s = 1; s < 4; s++) begin
         wr(A_MAIN, 32'(s << 2));
         wr(A_RES, exp[s]);
      end
      for (int s = 0; s < 4; s++) begin
         wr(A_MAIN, 32'(s << 2));
         expect_rd(A_RES, exp[s], "overlay");
      end
      wr(A_RES, 32'h4444_4444);
      wr(A_MAIN, 32'h0);
      expect_rd(A_RES, 32'h4444_4444, "overlay 11 write");
   endtask : t_overlay

   // one word through the engine; taps above poly_order_minus_one must be ignored
   task automatic t_crc(input bit dir);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      wr(A_MAIN, 32'h08);
      wr(A_RES, 32'h107);
      wr(A_MAIN, 32'h00);
      wr(A_RES, 32'h0);
      wr(A_POLY_ORDER_MINUS_ONE, 32'h7);
      wr(A_WORD_BITS_MINUS_ONE, 32'h7);
      wr(A_IN, 32'h1234_56B4);
      expect_rd(A_MAIN, 32'h01, "full before start");
      wr(A_MAIN, 32'h90);
      expect_rd(A_MAIN, 32'h91, "held without start");
      wr(A_MAIN, 32'hC0 | {30'h0, dir, 1'b0});
      apb(1'b0, A_MAIN, 32'h0, 4'h0, r, e);
      chk("busy after start", 32'h1, {31'h0, r[5]});
      while (r[5] === 1'b1 && n < 40) begin
         apb(1'b0, A_MAIN, 32'h0, 4'h0, r, e);
         n++;
      end
      chk("main after shift", 32'hC0 | {30'h0, dir, 1'b0}, r);
      chk("busy status", 32'h0, {31'h0, busyStatus});
      expect_rd(A_RES, crc_ref(32'hB4, 32'h107, 7, 7, dir), "checksum");
      wr(A_MAIN, 32'h0);
   endtask : t_crc

   // ==========================================================
   // run control
   // ==========================================================
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   // main sequence; reset held two cycles, setup from fifth edge on
   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset;
      t_fields;
      t_unmapped;
      t_overlay;
      t_crc(1'b1);
      t_crc(1'b0);
      end_sim;
   end

   // watchdog: tests need well under a thousand cycles
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
endmodule : crcsh_engine_bench
